// ---- rtl/mux_adc_pkg.sv ----
/*
 * shared constants of the multiplexed converter control block: channel count,
 * codes, timing counts and configuration selectors.
 * assumes a 100 MHz core clock; all counts are derived from that rate.
 */
package mux_adc_pkg;
   // ****************************************************************
   // geometry and coding
   // ****************************************************************
   localparam int CHANNELS = 8;
   localparam int CODE_BITS = 12;
   localparam int AVG_BITS = 16;
   localparam int OSR_BITS = 3;
   localparam logic [11:0] negative_full_scale_code = 12'h000;
   localparam logic [11:0] mid_scale_code = 12'h800;
   localparam logic [11:0] positive_full_scale_code = 12'hfff;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] PIN_CFG_RESET = 8'h00;      // all channels analog
   localparam logic [7:0] GPIO_CFG_RESET = 8'h00;
   localparam logic [7:0] DRIVE_CFG_RESET = 8'h00;
   localparam logic [7:0] OUT_LEVEL_RESET = 8'h00;
   localparam logic [7:0] SEQ_MASK_RESET = 8'h00;
   localparam logic [6:0] ADDR_BASE = 7'h10;          // strap code adds on top

   // ****************************************************************
   // configuration selectors on the cfg port
   // ****************************************************************
   localparam logic [2:0] SEL_PIN_CFG = 3'h0;
   localparam logic [2:0] SEL_GPIO_CFG = 3'h1;
   localparam logic [2:0] SEL_DRIVE_CFG = 3'h2;
   localparam logic [2:0] SEL_OUT_LEVELS = 3'h3;
   localparam logic [2:0] SEL_SEQ_MASK = 3'h4;
   localparam logic [2:0] SEL_MODE = 3'h5;            // [2:0] osr, [3] hs, [4] seq
   localparam logic [2:0] SEL_MANUAL_CH = 3'h6;
   localparam logic [2:0] SEL_ADDRESS = 3'h7;
   localparam int MODE_HS_BIT = 3;
   localparam int MODE_SEQ_BIT = 4;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
   localparam int STRETCH_FAST_NS = 1200;
   localparam int STRETCH_HS_NS = 950;
   localparam int GLITCH_FAST_NS = 50;
   localparam int GLITCH_HS_NS = 10;
   localparam int RST_TIME_MS = 5;
   localparam int CAL_TIME_NS = 2000;
   // longest times round down, least times round up
   localparam int STRETCH_FAST_CYC = STRETCH_FAST_NS / CLK_PERIOD_NS;
   localparam int STRETCH_HS_CYC = STRETCH_HS_NS / CLK_PERIOD_NS;
   localparam int GLITCH_FAST_CYC = (GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLITCH_HS_CYC = (GLITCH_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CYC = RST_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int CAL_CYC = CAL_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_conv = 2'b01,
      st_cal = 2'b10
   } conv_state_t;
endpackage

// ---- rtl/line_glitch_filter.sv ----
/*
 * glitch filter for one i2c line: two-flop synchroniser, then the clean
 * level only follows after the raw level stays put for the mode's count.
 * assumes the line is asynchronous to core_clk.
 */
`timescale 1ns/100ps
module line_glitch_filter (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic raw_line,
   input wire logic hs_mode,
   output logic clean_line
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [2:0] stable_cnt;
      logic clean;
   } filt_t;

   filt_t state;
   filt_t next_state;
   logic [2:0] need;

   // ****************************************************************
   // filtering
   // ****************************************************************
   // pulses shorter than the count never reach clean
   always_comb begin
      next_state = state;
      need = hs_mode ? 3'(mux_adc_pkg::GLITCH_HS_CYC) : 3'(mux_adc_pkg::GLITCH_FAST_CYC);
      next_state.sync1 = raw_line;
      next_state.sync2 = state.sync1;
      if (state.sync2 == state.clean) begin
         next_state.stable_cnt = 3'h0;
      end else if (state.stable_cnt + 3'h1 >= need) begin
         next_state.clean = state.sync2;
         next_state.stable_cnt = 3'h0;
      end else begin
         next_state.stable_cnt = state.stable_cnt + 3'h1;
      end
   end

   // idle i2c lines are high
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '{sync1: 1'b1, sync2: 1'b1, stable_cnt: 3'h0, clean: 1'b1};
      end else begin
         state <= next_state;
      end
   end

   assign clean_line = state.clean;
endmodule

// ---- rtl/mux_adc_gpio_control.sv ----
/*
 * control logic of an eight-channel multiplexed 12-bit converter with gpio:
 * channel configuration, gpio drive, conversion sequencing with averaging,
 * offset calibration, soft reset, scl stretching and line filtering.
 * assumes an i2c protocol engine on core_clk issues cfg writes and
 * conversion starts, and an analog front end returns raw_code in-domain.
 */
`timescale 1ns/100ps
module mux_adc_gpio_control #(
   parameter int RST_CYCLES = mux_adc_pkg::RST_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic cfg_write,
   input wire logic [2:0] cfg_sel,
   input wire logic [7:0] cfg_data,
   input wire logic cal_request,
   input wire logic soft_reset_request,
   input wire logic conv_start,
   input wire logic [2:0] addr_strap,
   input wire logic [11:0] raw_code,
   input wire logic [7:0] gpio_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic [7:0] gpio_out,
   output logic [7:0] gpio_oe_n,
   output logic [7:0] digital_input_levels,
   output logic [2:0] mux_channel,
   output logic sample_strobe,
   output logic [11:0] result_code,
   output logic [15:0] avg_result,
   output logic [2:0] result_channel,
   output logic result_valid,
   output logic cal_bit,
   output logic soft_reset_bit,
   output logic [6:0] bus_address,
   output logic scl_clean,
   output logic sda_clean,
   output logic scl_oe_n
);
   typedef struct packed {
      mux_adc_pkg::conv_state_t fsm;
      logic [7:0] pin_cfg;
      logic [7:0] gpio_cfg;
      logic [7:0] output_driver_type;
      logic [7:0] digital_output_levels;
      logic [7:0] seq_mask;
      logic [2:0] osr;
      logic hs_mode;
      logic seq_en;
      logic [2:0] manual_ch;
      logic [2:0] cur_ch;
      logic [6:0] address;
      logic strap_taken;
      logic [7:0] gpio_sync1;
      logic [7:0] gpio_sync2;
      logic [7:0] in_levels;
      logic [7:0] conv_cnt;
      logic [7:0] sample_cnt;
      logic [18:0] accum;
      logic [11:0] result;
      logic [15:0] avg;
      logic [2:0] res_ch;
      logic valid;
      logic cal;
      logic [9:0] cal_cnt;
      logic soft_rst;
      logic [19:0] rst_cnt;
      logic stretch;
   } ctrl_t;

   ctrl_t state;
   ctrl_t next_state;
   logic [7:0] analog_ch;
   logic [7:0] conv_len;
   logic [7:0] osr_total;
   logic [22:0] scaled;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // next enabled channel after cur, wrapping; stays put if none enabled
   function automatic logic [2:0] next_channel(input logic [7:0] mask, input logic [2:0] cur);
      logic [2:0] pick;
      logic [2:0] idx;
      pick = cur;
      for (int k = 8; k >= 1; k--) begin
         idx = 3'(cur + 3'(k));
         if (mask[idx]) begin
            pick = idx;
         end
      end
      return pick;
   endfunction

   // ****************************************************************
   // line filters
   // ****************************************************************
   line_glitch_filter scl_filter (
      .core_clk(core_clk),
      .reset(reset),
      .raw_line(scl_in),
      .hs_mode(state.hs_mode),
      .clean_line(scl_clean)
   );

   line_glitch_filter sda_filter (
      .core_clk(core_clk),
      .reset(reset),
      .raw_line(sda_in),
      .hs_mode(state.hs_mode),
      .clean_line(sda_clean)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      analog_ch = ~state.pin_cfg;
      conv_len = state.hs_mode ? 8'(mux_adc_pkg::STRETCH_HS_CYC)
                               : 8'(mux_adc_pkg::STRETCH_FAST_CYC);
      osr_total = 8'h01 << state.osr;
      scaled = {state.accum, 4'h0} >> state.osr;
      next_state.valid = 1'b0;

      // gpio input synchroniser; only the second stage is read
      next_state.gpio_sync1 = gpio_in;
      next_state.gpio_sync2 = state.gpio_sync1;
      next_state.in_levels = state.gpio_sync2 & state.pin_cfg & ~state.gpio_cfg;

      // address taken from the strap once after reset release and again as a soft reset begins
      if (!state.strap_taken) begin
         next_state.address = mux_adc_pkg::ADDR_BASE | {4'h0, addr_strap};
         next_state.strap_taken = 1'b1;
      end

      // configuration writes from the protocol engine
      if (cfg_write && !state.soft_rst) begin
         case (cfg_sel)
            mux_adc_pkg::SEL_PIN_CFG: next_state.pin_cfg = cfg_data;
            mux_adc_pkg::SEL_GPIO_CFG: next_state.gpio_cfg = cfg_data;
            mux_adc_pkg::SEL_DRIVE_CFG: next_state.output_driver_type = cfg_data;
            mux_adc_pkg::SEL_OUT_LEVELS: next_state.digital_output_levels = cfg_data;
            mux_adc_pkg::SEL_SEQ_MASK: next_state.seq_mask = cfg_data;
            mux_adc_pkg::SEL_MODE: begin
               next_state.osr = cfg_data[2:0];
               next_state.hs_mode = cfg_data[mux_adc_pkg::MODE_HS_BIT];
               next_state.seq_en = cfg_data[mux_adc_pkg::MODE_SEQ_BIT];
            end
            mux_adc_pkg::SEL_MANUAL_CH: next_state.manual_ch = cfg_data[2:0];
            mux_adc_pkg::SEL_ADDRESS: next_state.address = cfg_data[6:0];
            default: next_state.address = state.address;
         endcase
      end

      // conversion, averaging and calibration sequencer
      case (state.fsm)
         mux_adc_pkg::st_idle: begin
            if (cal_request) begin
               next_state.cal = 1'b1;
               next_state.cal_cnt = 10'h000;
               next_state.fsm = mux_adc_pkg::st_cal;
            end else if (conv_start && !state.soft_rst) begin
               next_state.cur_ch = state.seq_en
                  ? next_channel(state.seq_mask & analog_ch, state.cur_ch)
                  : state.manual_ch;
               next_state.accum = 19'h00000;
               next_state.sample_cnt = 8'h00;
               next_state.conv_cnt = 8'h00;
               next_state.stretch = 1'b1;
               next_state.fsm = mux_adc_pkg::st_conv;
            end
         end
         mux_adc_pkg::st_conv: begin
            if (state.conv_cnt + 8'h01 < conv_len) begin
               next_state.conv_cnt = state.conv_cnt + 8'h01;
            end else begin
               // the stretch window bounds one conversion; extra samples are internal
               next_state.stretch = 1'b0;
               next_state.conv_cnt = 8'h00;
               next_state.accum = state.accum + {7'h00, raw_code};
               next_state.result = raw_code;
               next_state.sample_cnt = state.sample_cnt + 8'h01;
               if (state.sample_cnt + 8'h01 >= osr_total) begin
                  next_state.fsm = mux_adc_pkg::st_idle;
                  next_state.res_ch = state.cur_ch;
                  next_state.valid = 1'b1;
               end
            end
         end
         mux_adc_pkg::st_cal: begin
            if (state.cal_cnt + 10'h001 >= 10'(mux_adc_pkg::CAL_CYC)) begin
               next_state.cal = 1'b0;
               next_state.fsm = mux_adc_pkg::st_idle;
            end else begin
               next_state.cal_cnt = state.cal_cnt + 10'h001;
            end
         end
         default: next_state.fsm = mux_adc_pkg::st_idle;
      endcase

      // average of 2^osr samples, rescaled to 16 bits
      if (state.valid) begin
         next_state.avg = scaled[15:0];
      end

      // soft reset: pin, gpio, drive, level and sequence-mask config back to defaults (mode and manual channel kept), bit clears after the count
      if (soft_reset_request && !state.soft_rst) begin
         next_state.soft_rst = 1'b1;
         next_state.rst_cnt = 20'h00000;
         next_state.pin_cfg = mux_adc_pkg::PIN_CFG_RESET;
         next_state.gpio_cfg = mux_adc_pkg::GPIO_CFG_RESET;
         next_state.output_driver_type = mux_adc_pkg::DRIVE_CFG_RESET;
         next_state.digital_output_levels = mux_adc_pkg::OUT_LEVEL_RESET;
         next_state.seq_mask = mux_adc_pkg::SEQ_MASK_RESET;
         next_state.strap_taken = 1'b0; // re-latch the strap
         next_state.fsm = mux_adc_pkg::st_idle;
         next_state.stretch = 1'b0;
         next_state.cal = 1'b0;
      end else if (state.soft_rst) begin
         if (state.rst_cnt + 20'h00001 >= 20'(RST_CYCLES)) begin
            next_state.soft_rst = 1'b0;
         end else begin
            next_state.rst_cnt = state.rst_cnt + 20'h00001;
         end
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
         state.fsm <= mux_adc_pkg::st_idle;
         state.pin_cfg <= mux_adc_pkg::PIN_CFG_RESET;
         state.gpio_cfg <= mux_adc_pkg::GPIO_CFG_RESET;
         state.output_driver_type <= mux_adc_pkg::DRIVE_CFG_RESET;
         state.digital_output_levels <= mux_adc_pkg::OUT_LEVEL_RESET;
         state.seq_mask <= mux_adc_pkg::SEQ_MASK_RESET;
         state.address <= mux_adc_pkg::ADDR_BASE;
         state.result <= mux_adc_pkg::negative_full_scale_code;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // pin drive
   // ****************************************************************
   // open drain pulls low for 0 and floats for 1, never drives high
   for (genvar ch = 0; ch < mux_adc_pkg::CHANNELS; ch++) begin : g_pin
      logic is_out;
      assign is_out = state.pin_cfg[ch] & state.gpio_cfg[ch];
      assign gpio_out[ch] = state.output_driver_type[ch] & state.digital_output_levels[ch];
      assign gpio_oe_n[ch] = !is_out | (!state.output_driver_type[ch]
                                        & state.digital_output_levels[ch]);
   end

   assign digital_input_levels = state.in_levels;
   assign mux_channel = state.cur_ch;
   assign sample_strobe = (state.fsm == mux_adc_pkg::st_conv) && (state.conv_cnt == 8'h00);
   assign result_code = state.result;
   assign avg_result = state.avg;
   assign result_channel = state.res_ch;
   assign result_valid = state.valid;
   assign cal_bit = state.cal;
   assign soft_reset_bit = state.soft_rst;
   assign bus_address = state.address;
   assign scl_oe_n = !state.stretch;
endmodule

// ---- dv/mux_adc_gpio_assertions.sv ----
/*
 * checker for the converter control block: stretch length and cause,
 * calibration and soft-reset bit lifetimes, reset values, address latch.
 * assumes it is bound to mux_adc_gpio_control and sees only its ports.
 */
`timescale 1ns/100ps
module mux_adc_gpio_checker #(
   parameter int RST_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic conv_start,
   input wire logic cal_request,
   input wire logic [2:0] addr_strap,
   input wire logic [7:0] gpio_oe_n,
   input wire logic [7:0] digital_input_levels,
   input wire logic sample_strobe,
   input wire logic result_valid,
   input wire logic cal_bit,
   input wire logic soft_reset_bit,
   input wire logic [6:0] bus_address,
   input wire logic scl_clean,
   input wire logic sda_clean,
   input wire logic scl_oe_n
);
   // ********
   // helper counters: stretch cycles and soft-reset cycles
   // ********
   typedef struct packed {
      logic [7:0] stretch;
      logic [31:0] srst;
   } span_t;
   span_t cnt, next_cnt;

   // counters restart whenever their signal drops, so each span is measured alone
   always_comb begin
      next_cnt = cnt;
      next_cnt.stretch = scl_oe_n ? 8'h00 : cnt.stretch + 8'h01;
      next_cnt.srst = soft_reset_bit ? cnt.srst + 32'h1 : 32'h0;
   end

   always_ff @(posedge core_clk) begin
      cnt <= reset ? '0 : next_cnt;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_stretch_cause: assert property ($fell(scl_oe_n) |-> $past(conv_start) && sample_strobe)
      else $error("stretch began without a conversion start");
   a_stretch_len: assert property ($rose(scl_oe_n) |-> cnt.stretch inside {8'h78, 8'h5f})
      else $error("stretch length is neither fast nor high-speed figure");
   a_stretch_max: assert property (cnt.stretch <= 8'h78)
      else $error("stretch longer than the fast-mode limit");
   a_valid_released: assert property (result_valid |-> scl_oe_n)
      else $error("result reported while scl still held");
   a_cal_cause: assert property ($rose(cal_bit) |-> $past(cal_request))
      else $error("calibration bit rose without a request");
   a_cal_self_clear: assert property ($rose(cal_bit) |-> ##199 cal_bit ##1 !cal_bit)
      else $error("calibration bit did not clear on time");
   a_srst_len: assert property ($fell(soft_reset_bit) |-> cnt.srst == 32'(RST_CYCLES))
      else $error("soft reset bit cleared at the wrong time");
   a_srst_max: assert property (cnt.srst <= 32'(RST_CYCLES))
      else $error("soft reset bit stands too long");
   a_reset_values: assert property ($fell(reset) |-> gpio_oe_n == 8'hff
         && digital_input_levels == 8'h00 && scl_oe_n && scl_clean && sda_clean)
      else $error("outputs not at reset values");
   a_addr_latch: assert property ($fell(reset) |=> bus_address ==
         (mux_adc_pkg::ADDR_BASE | {4'h0, $past(addr_strap)}))
      else $error("bus address not taken from the strap");

   c_conversion: cover property ($rose(scl_oe_n));
   c_calibration: cover property ($fell(cal_bit));
   c_soft_reset: cover property ($fell(soft_reset_bit));
endmodule

bind mux_adc_gpio_control mux_adc_gpio_checker #(.RST_CYCLES(RST_CYCLES)) u_mux_adc_gpio_checker (
   .core_clk, .reset, .conv_start, .cal_request, .addr_strap, .gpio_oe_n, .digital_input_levels,
   .sample_strobe, .result_valid, .cal_bit, .soft_reset_bit, .bus_address, .scl_clean,
   .sda_clean, .scl_oe_n);

// ---- dv/i2c_host_model.sv ----
/*
 * behavioural i2c host: pulls scl and sda low or releases them.
 * assumes pull-ups on both wires, resolved by the bench; scl idles high.
 */
`timescale 1ns/100ps
module i2c_host_model (
   input wire logic scl_wire,
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // start, nbits clocks of 80 ns, stop; the clock stands still between frames
   task automatic frame(input int nbits);
      int w;
      sda_low = 1'b1;
      #40 scl_low = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         #20 sda_low = i[0];
         #20 scl_low = 1'b0;
         // a stretching target keeps scl low: wait, but never forever
         w = 0;
         while (scl_wire !== 1'b1 && w < 400) begin
            #10 w++;
         end
         #40 scl_low = 1'b1;
      end
      #20 sda_low = 1'b1;
      #20 scl_low = 1'b0;
      #40 sda_low = 1'b0;
   endtask

   // lone low pulse on sda, for the noise filter
   task automatic sda_pulse(input int ns);
      sda_low = 1'b1;
      #(ns) sda_low = 1'b0;
   endtask
endmodule

// ---- dv/tb_mux_adc_gpio_control.sv ----
/*
 * self-checking bench for mux_adc_gpio_control with a behavioural i2c host.
 * assumes the package, the bound checker and the host model compile first.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_mux_adc_gpio_control;
   typedef struct packed {
      logic [2:0] ch;
      logic [11:0] code;
      logic [15:0] avg;
   } note_t;
   note_t exp_q[$];
   note_t n;
   logic core_clk = 1'b0, reset = 1'b1, cfg_write = 1'b0, cal_request = 1'b0;
   logic soft_reset_request = 1'b0, conv_start = 1'b0, use_fixed = 1'b1, prev_scl = 1'b1;
   logic [2:0] cfg_sel = 3'h0, addr_strap = 3'h5, ch_exp = 3'h0, osr = 3'h0;
   logic [7:0] cfg_data = 8'h00, gpio_in = 8'h00, pc, gc, dc, ol;
   logic [7:0] gpio_out, gpio_oe_n, digital_input_levels;
   logic [11:0] raw_code = 12'h000, result_code, fixed_code = 12'h000, r;
   logic [11:0] codes [4] = '{mux_adc_pkg::negative_full_scale_code,
      mux_adc_pkg::mid_scale_code, mux_adc_pkg::positive_full_scale_code, 12'h801};
   logic [2:0] mux_channel, result_channel, seq_ch [3] = '{3'h2, 3'h5, 3'h2};
   logic [15:0] avg_result;
   logic [23:0] sum = 24'h0;
   logic [6:0] bus_address;
   logic sample_strobe, result_valid, cal_bit, soft_reset_bit, scl_clean, sda_clean, scl_oe_n;
   logic scl_low, sda_low;
   wire scl_wire = ~(scl_low | ~scl_oe_n);
   wire sda_wire = ~sda_low;
   integer seed = 32'h9c90;
   int miscompares = 0, checked = 0, k = 0, nsamp = 1, scl_rises = 0, sda_lows = 0;

   initial forever #5 core_clk = ~core_clk;

   mux_adc_gpio_control #(.RST_CYCLES(50)) u_mux_adc_gpio_control (.core_clk, .reset,
      .cfg_write, .cfg_sel, .cfg_data, .cal_request, .soft_reset_request, .conv_start,
      .addr_strap, .raw_code, .gpio_in, .scl_in(scl_wire), .sda_in(sda_wire), .gpio_out,
      .gpio_oe_n, .digital_input_levels, .mux_channel, .sample_strobe, .result_code,
      .avg_result, .result_channel, .result_valid, .cal_bit, .soft_reset_bit, .bus_address,
      .scl_clean, .sda_clean, .scl_oe_n);
   i2c_host_model u_i2c_host_model (.scl_wire(scl_wire), .scl_low(scl_low), .sda_low(sda_low));

   // ********
   // drivers, result notes and monitors
   // ********
   // raw code moves on at every sample; the last sample of a run notes the expected result
   always @(posedge core_clk) begin
      if (sample_strobe === 1'b1) begin
         `CHK("mux_channel", ch_exp, mux_channel)
         r = use_fixed ? fixed_code : 12'($random(seed));
         raw_code <= r;
         sum = sum + 24'(r);
         k = k + 1;
         if (k == nsamp) exp_q.push_back({ch_exp, r, 16'((sum << 4) >> osr)});
      end
   end

   // each result pulse takes the oldest note; the average lands a cycle later
   always @(posedge core_clk) begin
      if (result_valid === 1'b1) begin
         n = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         `CHK("result_code", n.code, result_code)
         `CHK("result_channel", n.ch, result_channel)
         @(posedge core_clk);
         `CHK("avg_result", n.avg, avg_result)
      end
   end

   // filtered line activity, counted for the link tests
   always @(posedge core_clk) begin
      prev_scl <= scl_clean;
      if (scl_clean === 1'b1 && prev_scl === 1'b0) scl_rises++;
      if (sda_clean === 1'b0) sda_lows++;
   end

   task automatic cfg(input logic [2:0] s, input logic [7:0] d);
      @(posedge core_clk);
      cfg_sel <= s;
      cfg_data <= d;
      cfg_write <= 1'b1;
      @(posedge core_clk);
      cfg_write <= 1'b0;
   endtask

   // pulse one request (0 conversion, 1 calibration, 2 soft reset) and poll until settled
   task automatic run(input int which, output int lows, output int busy);
      int i;
      lows = 0;
      busy = 0;
      k = 0;
      sum = 24'h0;
      @(posedge core_clk);
      conv_start <= (which == 0);
      cal_request <= (which == 1);
      soft_reset_request <= (which == 2);
      @(posedge core_clk);
      {conv_start, cal_request, soft_reset_request} <= 3'h0;
      for (i = 0; i < 3000; i++) begin
         @(posedge core_clk);
         lows += (scl_oe_n === 1'b0);
         busy += (cal_bit === 1'b1 || soft_reset_bit === 1'b1);
         if (result_valid === 1'b1) break;
         if (which > 0 && i > 2 && cal_bit === 1'b0 && soft_reset_bit === 1'b0) break;
      end
   endtask

   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // a hang is cut short well after the whole sequence should be over
   initial begin
      #200_000;
      miscompares++;
      $display("[FAIL] watchdog expected finish seen hang");
      test_done;
   end

   initial begin
      int lo, bz;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK("bus_address", mux_adc_pkg::ADDR_BASE | 7'h5, bus_address)
      // random mixes of analog, input, open-drain and push-pull channels
      repeat (6) begin
         {pc, gc, dc, ol} = $random(seed);
         cfg(mux_adc_pkg::SEL_PIN_CFG, pc);
         cfg(mux_adc_pkg::SEL_GPIO_CFG, gc);
         cfg(mux_adc_pkg::SEL_DRIVE_CFG, dc);
         cfg(mux_adc_pkg::SEL_OUT_LEVELS, ol);
         gpio_in <= 8'($random(seed));
         repeat (6) @(posedge core_clk);
         `CHK("gpio_out", dc & ol, gpio_out)
         `CHK("gpio_oe_n", ~(pc & gc & (dc | ~ol)), gpio_oe_n)
         `CHK("digital_input_levels", gpio_in & pc & ~gc, digital_input_levels)
      end
      $display("test gpio done");
      // soft reset back to analog; a write made meanwhile must be dropped
      addr_strap <= 3'h2;
      fork
         run(2, lo, bz);
         begin
            repeat (8) @(posedge core_clk);
            cfg(mux_adc_pkg::SEL_PIN_CFG, 8'hff);
         end
      join
      `CHK("soft reset span", 50, bz)
      cfg(mux_adc_pkg::SEL_GPIO_CFG, 8'hff);
      cfg(mux_adc_pkg::SEL_OUT_LEVELS, 8'hff);
      repeat (4) @(posedge core_clk);
      `CHK("gpio_oe_n", 8'hff, gpio_oe_n)
      `CHK("bus_address", mux_adc_pkg::ADDR_BASE | 7'h2, bus_address)
      $display("test soft reset done");
      // calibration, with a conversion start that must be ignored meanwhile
      fork
         run(1, lo, bz);
         begin
            repeat (20) @(posedge core_clk);
            conv_start <= 1'b1;
            @(posedge core_clk);
            conv_start <= 1'b0;
         end
      join
      `CHK("calibration span", mux_adc_pkg::CAL_CYC, bz)
      `CHK("stretch during calibration", 0, lo)
      $display("test calibration done");
      // scale-point codes and one code above mid-scale, single samples, one channel each
      foreach (codes[j]) begin
         cfg(mux_adc_pkg::SEL_MANUAL_CH, 8'(j));
         ch_exp = 3'(j);
         fixed_code = codes[j];
         run(0, lo, bz);
         `CHK("fast stretch", mux_adc_pkg::STRETCH_FAST_CYC, lo)
      end
      // eight-sample average of changing codes on channel 6
      cfg(mux_adc_pkg::SEL_MANUAL_CH, 8'h06);
      cfg(mux_adc_pkg::SEL_MODE, 8'h03);
      {ch_exp, osr, nsamp, use_fixed} = {3'h6, 3'h3, 32'd8, 1'b0};
      run(0, lo, bz);
      $display("test codes done");
      // high-speed conversion while the host runs a frame through the stretch
      cfg(mux_adc_pkg::SEL_MODE, 8'h08);
      {osr, nsamp, use_fixed, fixed_code} = {3'h0, 32'd1, 1'b1, 12'h5a5};
      scl_rises = 0;
      fork
         u_i2c_host_model.frame(9);
         begin
            #205;
            run(0, lo, bz);
         end
      join
      `CHK("high-speed stretch", mux_adc_pkg::STRETCH_HS_CYC, lo)
      `CHK("scl rises", 10, scl_rises)
      // sequencing over channels 2 and 5
      cfg(mux_adc_pkg::SEL_MODE, 8'h10);
      cfg(mux_adc_pkg::SEL_MANUAL_CH, 8'h00);
      cfg(mux_adc_pkg::SEL_SEQ_MASK, 8'h24);
      foreach (seq_ch[j]) begin
         ch_exp = seq_ch[j];
         run(0, lo, bz);
      end
      // fast-mode noise filter: a 30 ns pulse vanishes, a 100 ns one passes
      cfg(mux_adc_pkg::SEL_MODE, 8'h00);
      sda_lows = 0;
      u_i2c_host_model.sda_pulse(30);
      repeat (10) @(posedge core_clk);
      `CHK("short sda pulse", 0, sda_lows)
      u_i2c_host_model.sda_pulse(100);
      repeat (10) @(posedge core_clk);
      `CHK("long sda pulse", 1'b1, sda_lows > 0)
      `CHK("pending notes", 0, exp_q.size())
      $display("test link done");
      test_done;
   end
endmodule
